// ===== logic/clma_top.sv
// cache line maintenance registers, hit lookup and victim choice
//
// Function
// - boot region bit set places line at 0x1D000000, clear at 0x1FC00000.
// - 20-bit tag in bits 23:4 is compared against physical address for hits.
// - only lines with valid flag (bit 3) set can hit.
// - locked lines (bit 2) are never chosen as replacement victim.
// - kind flag bit 1 marks instruction line when set, data line when clear.
// - full 32-bit word three of selected line is a read/write window.
// - word three window reads are blocked while code protection is active.
// - read-only 25-bit pseudo-lru state in bits 24:0, other bits zero; the code holds a 15-bit tree in bits 14:0, bits 24:15 read zero.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module clma_top (
  input wire logic mclk,
  input wire logic rst,
  input wire clma_pkg::clma_bus_t bus,
  output logic [31:0] rdata,
  input wire logic code_protect,
  input wire clma_pkg::clma_lookup_t lookup,
  output logic hit,
  output logic [clma_pkg::CLMA_IDX_W-1:0] hit_line,
  output logic hit_kind,
  output logic [clma_pkg::CLMA_IDX_W-1:0] victim_line,
  output logic victim_valid
);

  localparam int LINES = clma_pkg::CLMA_LINES;
  localparam int IW = clma_pkg::CLMA_IDX_W;

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  clma_pkg::clma_line_t [LINES-1:0] lines_ff;
  clma_pkg::clma_line_t [LINES-1:0] nxt_lines;
  clma_pkg::clma_line_t [LINES-1:0] prev_lines_ff;
  clma_pkg::clma_line_t sel_line;
  logic [IW-1:0] line_index_selection_ff;
  logic [IW-1:0] nxt_index;
  logic prot_meta_ff;
  logic prot_sync_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic w3_sel_ff;
  logic nxt_w3_sel;
  logic w3_wr;
  logic w3_rd;
  logic [31:0] w3_q;
  logic hit_ff;
  logic nxt_hit;
  logic [IW-1:0] hit_line_ff;
  logic [IW-1:0] nxt_hit_line;
  logic hit_kind_ff;
  logic nxt_hit_kind;
  logic [IW-1:0] victim_ff;
  logic [IW-1:0] nxt_victim;
  logic victim_valid_ff;
  logic nxt_victim_valid;
  logic [clma_pkg::CLMA_TREE_W-1:0] tree_state;
  logic [IW-1:0] tree_victim;
  logic [clma_pkg::CLMA_LRU_W-1:0] replacement_state_vector;
  logic wr_tag;
  logic rd_w3_req;

  assign sel_line = lines_ff[line_index_selection_ff];
  assign wr_tag = bus.wr && (bus.addr == clma_pkg::CLMA_OFF_TAG);
  assign rd_w3_req = bus.rd && (bus.addr == clma_pkg::CLMA_OFF_WORD3);
  assign replacement_state_vector = clma_pkg::CLMA_LRU_W'(tree_state); // upper bits zero

  //////////////////////////////////////////////////////////////////////////////
  // code protect pin synchroniser
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      prot_meta_ff <= 1'b1;
      prot_sync_ff <= 1'b1;
    end
    else
    begin
      prot_meta_ff <= code_protect;
      prot_sync_ff <= prot_meta_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // index selection and line tag writes
  always_comb
  begin
    nxt_index = line_index_selection_ff;
    nxt_lines = lines_ff;
    if (bus.wr && (bus.addr == clma_pkg::CLMA_OFF_INDEX))
      nxt_index = bus.wdata[IW-1:0];
    if (wr_tag)
    begin
      // only the selected line takes the new fields
      nxt_lines[line_index_selection_ff].boot_region_select =
        bus.wdata[clma_pkg::CLMA_BOOT_BIT];
      nxt_lines[line_index_selection_ff].line_tag_address =
        bus.wdata[clma_pkg::CLMA_TAG_HI:clma_pkg::CLMA_TAG_LO];
      nxt_lines[line_index_selection_ff].line_valid_flag =
        bus.wdata[clma_pkg::CLMA_VALID_BIT];
      nxt_lines[line_index_selection_ff].line_lock_flag =
        bus.wdata[clma_pkg::CLMA_LOCK_BIT];
      nxt_lines[line_index_selection_ff].line_kind_flag =
        bus.wdata[clma_pkg::CLMA_KIND_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      line_index_selection_ff <= '0;
      for (int i = 0; i < LINES; i++)
      begin
        lines_ff[i] <= '{clma_pkg::CLMA_BOOT_RST, clma_pkg::CLMA_TAG_RST,
                         clma_pkg::CLMA_VALID_RST, clma_pkg::CLMA_LOCK_RST,
                         clma_pkg::CLMA_KIND_RST};
      end
      prev_lines_ff <= '0;
    end
    else
    begin
      line_index_selection_ff <= nxt_index;
      lines_ff <= nxt_lines;
      prev_lines_ff <= lines_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // word three window storage
  assign w3_wr = bus.wr && (bus.addr == clma_pkg::CLMA_OFF_WORD3);
  assign w3_rd = rd_w3_req && !prot_sync_ff;

  clma_word_mem #(
    .WIDTH(32),
    .DEPTH(LINES),
    .AW(IW)
  ) u_word3 (
    .mclk(mclk),
    .rst(rst),
    .wr(w3_wr),
    .waddr(line_index_selection_ff),
    .wdata(bus.wdata),
    .rd(w3_rd),
    .raddr(line_index_selection_ff),
    .rdata(w3_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register read path
  always_comb
  begin
    nxt_rdata = 32'h00000000;
    nxt_w3_sel = w3_rd;
    if (bus.rd)
    begin
      case (bus.addr)
        clma_pkg::CLMA_OFF_INDEX: nxt_rdata = 32'(line_index_selection_ff);
        clma_pkg::CLMA_OFF_TAG:
          nxt_rdata = {sel_line.boot_region_select, 7'h00, sel_line.line_tag_address,
                       sel_line.line_valid_flag, sel_line.line_lock_flag,
                       sel_line.line_kind_flag, 1'b0};
        clma_pkg::CLMA_OFF_LRU: nxt_rdata = 32'(replacement_state_vector);
        default: nxt_rdata = 32'h00000000; // protected word three reads zero
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata_ff <= 32'h00000000;
      w3_sel_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      w3_sel_ff <= nxt_w3_sel;
    end
  end

  // both sources are registers
  assign rdata = w3_sel_ff ? w3_q : rdata_ff;

  //////////////////////////////////////////////////////////////////////////////
  // hit detection, lowest matching line wins
  always_comb
  begin
    logic match;
    logic [7:0] region;
    match = 1'b0;
    region = 8'h00;
    nxt_hit = 1'b0;
    nxt_hit_line = '0;
    nxt_hit_kind = 1'b0;
    for (int i = LINES - 1; i >= 0; i--)
    begin
      region = lines_ff[i].boot_region_select ? clma_pkg::CLMA_BOOT_REGION[31:24] :
               clma_pkg::CLMA_MAIN_REGION[31:24];
      match = lines_ff[i].line_valid_flag &&
              (lookup.addr[31:24] == region) &&
              (lookup.addr[clma_pkg::CLMA_TAG_HI:clma_pkg::CLMA_TAG_LO] ==
               lines_ff[i].line_tag_address);
      if (lookup.req && match)
      begin
        nxt_hit = 1'b1;
        nxt_hit_line = IW'(i);
        nxt_hit_kind = lines_ff[i].line_kind_flag;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // victim choice skips locked lines
  always_comb
  begin
    logic [IW-1:0] cand;
    cand = '0;
    nxt_victim = tree_victim;
    nxt_victim_valid = 1'b0;
    for (int k = LINES - 1; k >= 0; k--)
    begin
      cand = tree_victim + IW'(k);
      if (!lines_ff[cand].line_lock_flag)
      begin
        nxt_victim = cand;
        nxt_victim_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      hit_ff <= 1'b0;
      hit_line_ff <= '0;
      hit_kind_ff <= 1'b0;
      victim_ff <= '0;
      victim_valid_ff <= 1'b0;
    end
    else
    begin
      hit_ff <= nxt_hit;
      hit_line_ff <= nxt_hit_line;
      hit_kind_ff <= nxt_hit_kind;
      victim_ff <= nxt_victim;
      victim_valid_ff <= nxt_victim_valid;
    end
  end

  // a hit marks its line most recently used
  clma_plru #(
    .IDX_W(IW),
    .TREE_W(clma_pkg::CLMA_TREE_W)
  ) u_plru (
    .mclk(mclk),
    .rst(rst),
    .touch(hit_ff),
    .touch_line(hit_line_ff),
    .state(tree_state),
    .victim(tree_victim)
  );

  assign hit = hit_ff;
  assign hit_line = hit_line_ff;
  assign hit_kind = hit_kind_ff;
  assign victim_line = victim_ff;
  assign victim_valid = victim_valid_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  AST_BOOT_REGION: assert property (@(posedge mclk) disable iff (rst)
    hit_ff |-> ($past(lookup.addr[31:24]) ==
      (prev_lines_ff[hit_line_ff].boot_region_select ? 8'h1D : 8'h1F)))
    else $error("hit outside the line region");

  AST_TAG_MATCH: assert property (@(posedge mclk) disable iff (rst)
    hit_ff |-> ($past(lookup.addr[23:4]) == prev_lines_ff[hit_line_ff].line_tag_address))
    else $error("hit with mismatched tag");

  AST_VALID_ONLY: assert property (@(posedge mclk) disable iff (rst)
    hit_ff |-> prev_lines_ff[hit_line_ff].line_valid_flag)
    else $error("invalid line produced a hit");

  AST_LOCK_SKIP: assert property (@(posedge mclk) disable iff (rst)
    victim_valid_ff |-> !prev_lines_ff[victim_ff].line_lock_flag)
    else $error("locked line chosen as victim");

  AST_KIND_FLAG: assert property (@(posedge mclk) disable iff (rst)
    hit_ff |-> (hit_kind_ff == prev_lines_ff[hit_line_ff].line_kind_flag))
    else $error("hit kind differs from line kind");

  AST_WORD3_RW: assert property (@(posedge mclk) disable iff (rst)
    (w3_wr ##1 (w3_rd && $stable(line_index_selection_ff) && !bus.wr))
      |=> (rdata == $past(bus.wdata, 2)))
    else $error("word three readback mismatch");

  AST_PROTECT_BLOCK: assert property (@(posedge mclk) disable iff (rst)
    (rd_w3_req && prot_sync_ff) |=> (rdata == 32'h00000000))
    else $error("protected word three read leaked data");

  AST_LRU_READ: assert property (@(posedge mclk) disable iff (rst)
    (bus.rd && (bus.addr == clma_pkg::CLMA_OFF_LRU))
      |=> ((rdata[31:25] == 7'h00) && (rdata[24:0] == $past(replacement_state_vector))))
    else $error("lru read wrong");

  AST_SELECT_ONLY: assert property (@(posedge mclk) disable iff (rst)
    wr_tag |=> ((lines_ff ^ prev_lines_ff) &
      ~({{(24*(LINES-1)){1'b0}}, 24'hFFFFFF} << (24 * $past(line_index_selection_ff))))
      == '0)
    else $error("tag write touched another line");

endmodule

// ===== logic/clma_pkg.sv
// shared constants and carrier types of the cache line maintenance block
package clma_pkg;

  // geometry
  localparam int CLMA_LINES = 16;
  localparam int CLMA_IDX_W = 4;
  localparam int CLMA_ADDR_W = 8;
  localparam int CLMA_LRU_W = 25;
  localparam int CLMA_TREE_W = 15;
  localparam int CLMA_TAG_W = 20;

  // register byte offsets
  localparam logic [7:0] CLMA_OFF_INDEX = 8'h00;
  localparam logic [7:0] CLMA_OFF_TAG = 8'h04;
  localparam logic [7:0] CLMA_OFF_WORD3 = 8'h08;
  localparam logic [7:0] CLMA_OFF_LRU = 8'h0C;

  // tag register field positions
  localparam int CLMA_BOOT_BIT = 31;
  localparam int CLMA_TAG_HI = 23;
  localparam int CLMA_TAG_LO = 4;
  localparam int CLMA_VALID_BIT = 3;
  localparam int CLMA_LOCK_BIT = 2;
  localparam int CLMA_KIND_BIT = 1;

  // physical regions chosen by the boot region select bit
  localparam logic [31:0] CLMA_BOOT_REGION = 32'h1D000000;
  localparam logic [31:0] CLMA_MAIN_REGION = 32'h1FC00000;

  // reset values of the line fields and the lru state
  localparam logic CLMA_BOOT_RST = 1'b0;
  localparam logic [19:0] CLMA_TAG_RST = 20'h00000;
  localparam logic CLMA_VALID_RST = 1'b0;
  localparam logic CLMA_LOCK_RST = 1'b0;
  localparam logic CLMA_KIND_RST = 1'b1;
  localparam logic [CLMA_LRU_W-1:0] CLMA_LRU_RST = 25'h0000000;

  // one cache line's tag state
  typedef struct packed {
    logic boot_region_select;
    logic [CLMA_TAG_W-1:0] line_tag_address;
    logic line_valid_flag;
    logic line_lock_flag;
    logic line_kind_flag;
  } clma_line_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [CLMA_ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } clma_bus_t;

  // hit lookup request
  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } clma_lookup_t;

endpackage

// ===== logic/clma_word_mem.sv
// data word storage with registered read port
`timescale 1ns/1ps
module clma_word_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic rd,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_ff;
  logic [WIDTH-1:0] nxt_rdata;

  // read register loads only on a read
  always_comb
  begin
    nxt_rdata = rd ? mem[raddr] : rdata_ff;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata_ff <= '0;
    else
      rdata_ff <= nxt_rdata;
  end

  // array itself carries no reset
  always_ff @(posedge mclk)
  begin
    if (wr)
      mem[waddr] <= wdata;
  end

  assign rdata = rdata_ff;

endmodule

// ===== logic/clma_plru.sv
// tree pseudo-lru state with victim walk
`timescale 1ns/1ps
module clma_plru #(
  parameter int IDX_W = 4,
  parameter int TREE_W = 15
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic touch,
  input wire logic [IDX_W-1:0] touch_line,
  output logic [TREE_W-1:0] state,
  output logic [IDX_W-1:0] victim
);

  logic [TREE_W-1:0] tree_ff;
  logic [TREE_W-1:0] nxt_tree;

  // point every node on the touched path away from it
  always_comb
  begin
    int n;
    n = 1;
    nxt_tree = tree_ff;
    if (touch)
    begin
      for (int d = 0; d < IDX_W; d++)
      begin
        nxt_tree[n-1] = ~touch_line[IDX_W-1-d];
        n = 2 * n + int'(touch_line[IDX_W-1-d]);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      tree_ff <= '0;
    else
      tree_ff <= nxt_tree;
  end

  // follow the node bits down to a leaf
  always_comb
  begin
    int m;
    m = 1;
    for (int d = 0; d < IDX_W; d++)
      m = 2 * m + int'(tree_ff[m-1]);
    victim = IDX_W'(m - (1 << IDX_W));
  end

  assign state = tree_ff;

endmodule

// ===== bench/tb_top.sv
// self-checking bench for the cache line maintenance block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_top;
  logic mclk;
  logic rst;
  clma_pkg::clma_bus_t bus;
  logic [31:0] rdata;
  logic code_protect;
  clma_pkg::clma_lookup_t lookup;
  logic hit;
  logic [3:0] hit_line;
  logic hit_kind;
  logic [3:0] victim_line;
  logic victim_valid;
  int n_mismatch;
  int n_checks;
  int cycles;
  logic [31:0] rd_val;

  clma_top u_dut (
    .mclk(mclk),
    .rst(rst),
    .bus(bus),
    .rdata(rdata),
    .code_protect(code_protect),
    .lookup(lookup),
    .hit(hit),
    .hit_line(hit_line),
    .hit_kind(hit_kind),
    .victim_line(victim_line),
    .victim_valid(victim_valid)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // write strobe followed at once by a read strobe on the same address
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge mclk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 q = rdata;
  endtask

  // one lookup request, registered answer
  task automatic look(input logic [31:0] a);
    @(posedge mclk);
    lookup.req <= 1'b1;
    lookup.addr <= a;
    @(posedge mclk);
    lookup.req <= 1'b0;
    #1;
  endtask

  // tag register image with the unused bits clear
  function automatic logic [31:0] tagv(input logic b, input logic [19:0] t, input logic v,
                                       input logic l, input logic k);
    tagv = {b, 7'h00, t, v, l, k, 1'b0};
  endfunction

  function automatic logic [31:0] hit_addr(input logic b, input logic [19:0] t);
    hit_addr = {(b ? 8'h1D : 8'h1F), t, 4'h5};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // reset state of line 0, replacement state and an unmapped place
  task automatic t_reset();
    rd_reg(8'h04, rd_val);
    `CHK("tag_rst", 32'h00000002, rd_val)
    rd_reg(8'h0C, rd_val);
    `CHK("lru_rst", 32'h00000000, rd_val)
    rd_reg(8'h10, rd_val);
    `CHK("unmapped", 32'h00000000, rd_val)
    `CHK("victim_valid_rst", 1'b1, victim_valid)
  endtask

  // every line gets its own tag and reads it back with the unused bits clear
  task automatic t_tag();
    for (int i = 0; i < 16; i++)
    begin
      wr_reg(8'h00, 32'(i));
      wr_reg(8'h04, tagv(i[0], 20'hA5000 + 20'(i), 1'b1, 1'b0, i[1]));
    end
    for (int i = 0; i < 16; i++)
    begin
      wr_reg(8'h00, 32'(i));
      rd_reg(8'h04, rd_val);
      `CHK("tag_rb", tagv(i[0], 20'hA5000 + 20'(i), 1'b1, 1'b0, i[1]), rd_val)
    end
  endtask

  // hits by region and tag, misses by region and by valid flag
  task automatic t_hit();
    for (int i = 0; i < 16; i++)
    begin
      look(hit_addr(i[0], 20'hA5000 + 20'(i)));
      `CHK("hit", 1'b1, hit)
      `CHK("hit_line", 4'(i), hit_line)
      `CHK("hit_kind", i[1], hit_kind)
      look(hit_addr(~i[0], 20'hA5000 + 20'(i)));
      `CHK("miss_region", 1'b0, hit)
    end
    wr_reg(8'h00, 32'h00000003);
    wr_reg(8'h04, tagv(1'b1, 20'hA5003, 1'b0, 1'b0, 1'b1));
    look(hit_addr(1'b1, 20'hA5003));
    `CHK("miss_invalid", 1'b0, hit)
    // all nodes point left after the ascending hits; a hit on line 0 turns its path right
    look(hit_addr(1'b0, 20'hA5000));
    `CHK("hit_line0", 4'h0, hit_line)
    rd_reg(8'h0C, rd_val);
    `CHK("lru_unused", 17'h00000, rd_val[31:15])
    `CHK("lru_state", 32'h0000008B, rd_val)
    wr_reg(8'h0C, 32'h00000000);
    rd_reg(8'h0C, rd_val);
    `CHK("lru_read_only", 32'h0000008B, rd_val)
  endtask

  // word three window under and out of protection
  task automatic t_word();
    wr_reg(8'h00, 32'h00000002);
    wr_reg(8'h08, 32'hCAFE0002);
    rd_reg(8'h08, rd_val);
    `CHK("w3_protected", 32'h00000000, rd_val)
    @(posedge mclk);
    code_protect <= 1'b0;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(8'h00, 32'(i));
      wr_reg(8'h08, 32'hC0DE0000 + 32'(i));
    end
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(8'h00, 32'(i));
      rd_reg(8'h08, rd_val);
      `CHK("w3_rb", 32'hC0DE0000 + 32'(i), rd_val)
    end
    wr_rd(8'h08, 32'h5EED0003, rd_val);
    `CHK("w3_b2b", 32'h5EED0003, rd_val)
    @(posedge mclk);
    code_protect <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_reg(8'h08, rd_val);
    `CHK("w3_reprotected", 32'h00000000, rd_val)
  endtask

  // locked lines are never offered for replacement
  task automatic t_lock();
    for (int i = 0; i < 16; i++)
    begin
      if (i != 9)
      begin
        wr_reg(8'h00, 32'(i));
        wr_reg(8'h04, tagv(1'b0, 20'h00000, 1'b0, 1'b1, 1'b1));
      end
    end
    repeat (3) @(posedge mclk);
    #1;
    `CHK("victim_line", 4'h9, victim_line)
    `CHK("victim_valid", 1'b1, victim_valid)
    wr_reg(8'h00, 32'h00000009);
    wr_reg(8'h04, tagv(1'b0, 20'h00000, 1'b0, 1'b1, 1'b1));
    repeat (3) @(posedge mclk);
    #1;
    `CHK("victim_none", 1'b0, victim_valid)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    n_mismatch = 0;
    n_checks = 0;
    rst = 1'b1;
    bus = '0;
    lookup = '0;
    code_protect = 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_tag();
    t_hit();
    t_word();
    t_lock();
    close_out();
  end
endmodule
